// >>> verilog/bccs_pkg.sv
// Package of constants and types for the battery charge control sequencer.
package bccs_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets on the APB slave.
   // ----------------------------------------------------------------
   localparam logic [7:0] LIM_ADDR = 8'h00;
   localparam logic [7:0] CHG_ADDR = 8'h04;
   localparam logic [7:0] TERM_ADDR = 8'h08;
   localparam logic [7:0] APP_ADDR = 8'h0c;
   localparam logic [7:0] SPC_ADDR = 8'h10;
   localparam logic [7:0] STAT_ADDR = 8'h14;
   localparam logic [7:0] EVT_ADDR = 8'h18;
   // ----------------------------------------------------------------
   // Reset values and field positions.
   // ----------------------------------------------------------------
   localparam logic [7:0] LIM_RST = 8'h80;
   localparam logic [7:0] CHG_RST = 8'h00;
   localparam logic [7:0] TERM_RST = 8'h04;
   localparam logic [7:0] APP_RST = 8'h78;
   localparam logic [7:0] SPC_RST = 8'h00;
   localparam int SRC_BIT = 7;
   localparam int DISCHG_BIT = 0;
   localparam int DISRCH_BIT = 1;
   localparam int DISNTC_BIT = 2;
   localparam int SPRIO_BIT = 5;
   // ----------------------------------------------------------------
   // Encodings of limits, charger modes and termination methods.
   // ----------------------------------------------------------------
   localparam logic [2:0] LIM_100MA = 3'h0;
   localparam logic [2:0] LIM_500MA = 3'h1;
   localparam logic [2:0] LIM_1500MA = 3'h3;
   localparam logic [1:0] MODE_HOLD = 2'h0;
   localparam logic [1:0] MODE_TRKL = 2'h1;
   localparam logic [1:0] MODE_CC = 2'h2;
   localparam logic [1:0] MODE_CV = 2'h3;
   localparam logic [1:0] TM_CUR_TIMER = 2'h0;
   localparam logic [1:0] TM_CV_TIMER = 2'h1;
   localparam logic [1:0] TM_CUR = 2'h2;
   localparam logic [1:0] TM_EITHER = 2'h3;
   // ----------------------------------------------------------------
   // Times in their own units and the clock rate.
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned NTC_PERIOD_S = 5;
   localparam int unsigned NTC_MEAS_MS = 16;
   localparam int unsigned MINUTE_S = 60;
   localparam logic [8:0] TRKL_MIN = 9'h01e;
   localparam logic [8:0] TERM_SHORT_MIN = 9'h002;
   localparam logic [8:0] TERM_LONG_MIN = 9'h00a;
   localparam logic [8:0] SAFETY_MIN = 9'h0f0;
   localparam int NUM_IN = 13;
   // ----------------------------------------------------------------
   // Charge sequencer states.
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_INIT = 7'h01,
      ST_STBY = 7'h02,
      ST_TRKL = 7'h04,
      ST_CC = 7'h08,
      ST_CV = 7'h10,
      ST_HOLD = 7'h20,
      ST_FAULT = 7'h40
   } bccs_state_t;
endpackage

// >>> verilog/bccs_sync.sv
// Two-flop synchroniser bank for the comparator and pin inputs.
`timescale 1ns/100ps
`default_nettype none
module bccs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   // The first stage feeds only the second stage.
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               meta_ff[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_ff[i] <= async_in[i];
               sync_out[i] <= meta_ff[i];
            end
         end
      end
   endgenerate
endmodule // bccs_sync
`default_nettype wire

// >>> verilog/bccs_charger.sv
// Charge control sequencer with its APB register file.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Function
// R1: Source bit picks register code or pin.
// R2: Pin low 500mA, pin high 1.5A.
// R3: 100mA until rail settles, then configured.
// R4: Pre-regulator runs only above lockout.
// R5: Report input supply presence in status.
// R6: Priority 0: low rail stops charging.
// R7: Priority 1: low rail reduces current instead.
// R8: Ideal diode follows rail below battery.
// R9: Trickle charge below threshold, 25mA steps.
// R10: Trickle over half hour sets fault.
// R11: Above threshold, constant current 100mA steps.
// R12: Load first; input limit always applied.
// R13: Float voltage reached moves to CV.
// R14: Termination uses the method field.
// R15: Power-on: below 3.9V charge, else standby.
// R16: Standby recharge below 3.9V, cool, half timers.
// R17: Hot or cold thermistor pauses charging.
// R18: Grounded thermistor disables temperature pausing.
// R19: Full and very hot: discharge to 3.9V.
// R20: Bias only while measuring, 16ms every 5s.
// R21: Method codes: timers, current, or either.
// R22: Completion rising edge sets W1C event.
// R23: Hold then resume interrupted phase.
module bccs_charger import bccs_pkg::*; #(
   parameter int unsigned NTC_PERIOD_CYC = NTC_PERIOD_S * CLK_HZ,
   parameter int unsigned NTC_MEAS_CYC = NTC_MEAS_MS * (CLK_HZ / 1000),
   parameter int unsigned MINUTE_CYC = MINUTE_S * CLK_HZ
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic limit_select_pin,
   input wire logic input_uvlo_ok,
   input wire logic rail_settled,
   input wire logic system_rail_low,
   input wire logic system_rail_below_bat,
   input wire logic bat_below_trickle,
   input wire logic bat_at_float,
   input wire logic bat_below_recharge,
   input wire logic term_current_reached,
   input wire logic ntc_hot,
   input wire logic ntc_cold,
   input wire logic ntc_grounded,
   input wire logic ntc_discharge_hot,
   output logic prereg_en,
   output logic [2:0] input_limit_sel,
   output logic charge_en,
   output logic charge_reduce,
   output logic [1:0] charge_mode,
   output logic [2:0] trickle_current_code,
   output logic [3:0] target_charge_current,
   output logic [1:0] float_sel,
   output logic diode_switch_on,
   output logic ext_diode_gate_out,
   output logic thermistor_bias_out,
   output logic discharge_en
);
   // ----------------------------------------------------------------
   // Input synchronisers.
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0] s_in;
   bccs_sync #(.W(NUM_IN)) u_sync (
      .clk(clk),
      .reset(reset),
      .async_in({ntc_discharge_hot, ntc_grounded, ntc_cold, ntc_hot,
                 term_current_reached, bat_below_recharge, bat_at_float,
                 bat_below_trickle, system_rail_below_bat, system_rail_low,
                 rail_settled, input_uvlo_ok, limit_select_pin}),
      .sync_out(s_in)
   );
   logic s_pin, s_uvlo, s_settled, s_rail_low, s_below_bat, s_below_trkl;
   logic s_float, s_below_rch, s_term_cur, s_hot, s_cold, s_gnd, s_disch;
   assign {s_disch, s_gnd, s_cold, s_hot, s_term_cur, s_below_rch, s_float,
           s_below_trkl, s_below_bat, s_rail_low, s_settled, s_uvlo,
           s_pin} = s_in;

   // ----------------------------------------------------------------
   // APB register file.
   // ----------------------------------------------------------------
   logic [7:0] lim_cfg_ff, chg_cfg_ff, term_cfg_ff, app_cfg_ff, spc_cfg_ff;
   logic [7:0] nxt_lim_cfg, nxt_chg_cfg, nxt_term_cfg, nxt_app_cfg;
   logic [7:0] nxt_spc_cfg;
   logic evt_ff, nxt_evt, done_dly_ff, nxt_done_dly;
   logic [31:0] nxt_prdata;
   logic nxt_pready, nxt_pslverr, acc, wr, hit;
   logic [13:0] status;
   logic done_ff, fault_ff, timeout_ff, hot_ff, cold_ff, gnd_ff, disch_ff;
   bccs_state_t state_ff;

   assign status = {prereg_en, s_rail_low, done_ff, charge_en, gnd_ff,
                    discharge_en, charge_reduce, timeout_ff, fault_ff,
                    charge_mode, hot_ff, cold_ff, s_uvlo}; // R5
   assign hit = (paddr == LIM_ADDR) || (paddr == CHG_ADDR) ||
                (paddr == TERM_ADDR) || (paddr == APP_ADDR) ||
                (paddr == SPC_ADDR) || (paddr == STAT_ADDR) ||
                (paddr == EVT_ADDR);
   // Access is answered one cycle after penable; a write lands with pready.
   assign acc = psel && penable && !pready;
   assign wr = psel && penable && pready && pwrite && hit;

   // Next values of the register file and the bus answer.
   always_comb begin
      nxt_lim_cfg = lim_cfg_ff;
      nxt_chg_cfg = chg_cfg_ff;
      nxt_term_cfg = term_cfg_ff;
      nxt_app_cfg = app_cfg_ff;
      nxt_spc_cfg = spc_cfg_ff;
      nxt_pready = acc;
      nxt_pslverr = acc && !hit;
      nxt_prdata = 32'h0;
      nxt_done_dly = done_ff;
      nxt_evt = evt_ff;
      if (wr) begin
         unique case (paddr)
            LIM_ADDR: nxt_lim_cfg = pwdata[7:0];
            CHG_ADDR: nxt_chg_cfg = pwdata[7:0];
            TERM_ADDR: nxt_term_cfg = pwdata[7:0];
            APP_ADDR: nxt_app_cfg = pwdata[7:0];
            SPC_ADDR: nxt_spc_cfg = pwdata[7:0];
            EVT_ADDR: nxt_evt = evt_ff && !pwdata[0];
            default: nxt_evt = evt_ff;
         endcase
      end
      // A completion edge beats a clear in the same cycle.
      if (done_ff && !done_dly_ff) begin
         nxt_evt = 1'b1; // R22
      end
      if (acc && !pwrite) begin
         unique case (paddr)
            LIM_ADDR: nxt_prdata = {24'h0, lim_cfg_ff};
            CHG_ADDR: nxt_prdata = {24'h0, chg_cfg_ff};
            TERM_ADDR: nxt_prdata = {24'h0, term_cfg_ff};
            APP_ADDR: nxt_prdata = {24'h0, app_cfg_ff};
            SPC_ADDR: nxt_prdata = {24'h0, spc_cfg_ff};
            STAT_ADDR: nxt_prdata = {18'h0, status};
            EVT_ADDR: nxt_prdata = {31'h0, evt_ff};
            default: nxt_prdata = 32'h0;
         endcase
      end
   end

   // Register file and bus answer flops.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lim_cfg_ff <= LIM_RST;
         chg_cfg_ff <= CHG_RST;
         term_cfg_ff <= TERM_RST;
         app_cfg_ff <= APP_RST;
         spc_cfg_ff <= SPC_RST;
         evt_ff <= 1'b0;
         done_dly_ff <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         lim_cfg_ff <= nxt_lim_cfg;
         chg_cfg_ff <= nxt_chg_cfg;
         term_cfg_ff <= nxt_term_cfg;
         app_cfg_ff <= nxt_app_cfg;
         spc_cfg_ff <= nxt_spc_cfg;
         evt_ff <= nxt_evt;
         done_dly_ff <= nxt_done_dly;
         pready <= nxt_pready;
         pslverr <= nxt_pslverr;
         prdata <= nxt_prdata;
      end
   end

   // ----------------------------------------------------------------
   // Thermistor sampling.
   // ----------------------------------------------------------------
   logic [31:0] per_cnt_ff, nxt_per_cnt, meas_cnt_ff, nxt_meas_cnt;
   logic nxt_bias, nxt_hot, nxt_cold, nxt_gnd, nxt_disch, pause;

   // Bias is only on during a window; flags are caught at its end so the
   // divider has settled, at the price of up to 5 s of reaction time.
   always_comb begin
      nxt_per_cnt = per_cnt_ff;
      nxt_meas_cnt = meas_cnt_ff;
      nxt_bias = thermistor_bias_out;
      nxt_hot = hot_ff;
      nxt_cold = cold_ff;
      nxt_gnd = gnd_ff;
      nxt_disch = disch_ff;
      if (!thermistor_bias_out) begin
         nxt_per_cnt = per_cnt_ff + 32'h1;
         if (per_cnt_ff >= NTC_PERIOD_CYC - 1) begin
            nxt_per_cnt = 32'h0;
            nxt_meas_cnt = 32'h0;
            nxt_bias = 1'b1; // R20
         end
      end else begin
         nxt_per_cnt = per_cnt_ff + 32'h1;
         nxt_meas_cnt = meas_cnt_ff + 32'h1;
         if (meas_cnt_ff >= NTC_MEAS_CYC - 1) begin
            nxt_bias = 1'b0; // R20
            nxt_hot = s_hot;
            nxt_cold = s_cold;
            nxt_gnd = s_gnd;
            nxt_disch = s_disch;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         per_cnt_ff <= 32'h0;
         meas_cnt_ff <= 32'h0;
         thermistor_bias_out <= 1'b0;
         hot_ff <= 1'b0;
         cold_ff <= 1'b0;
         gnd_ff <= 1'b0;
         disch_ff <= 1'b0;
      end else begin
         per_cnt_ff <= nxt_per_cnt;
         meas_cnt_ff <= nxt_meas_cnt;
         thermistor_bias_out <= nxt_bias;
         hot_ff <= nxt_hot;
         cold_ff <= nxt_cold;
         gnd_ff <= nxt_gnd;
         disch_ff <= nxt_disch;
      end
   end

   // Pausing is off when the sense pin is grounded or software masks it.
   assign pause = (hot_ff || cold_ff) && !gnd_ff &&
                  !spc_cfg_ff[DISNTC_BIT]; // R17 R18

   // ----------------------------------------------------------------
   // Charge sequencer, timers and outputs.
   // ----------------------------------------------------------------
   bccs_state_t nxt_state, resume_ff, nxt_resume;
   logic [31:0] min_cnt_ff, nxt_min_cnt;
   logic [8:0] phase_min_ff, nxt_phase_min, safe_min_ff, nxt_safe_min;
   logic [8:0] term_lim, safe_lim;
   logic phase_run_ff, nxt_phase_run, half_ff, nxt_half;
   logic nxt_done, nxt_fault, nxt_timeout, block, charging, start, tmr_evt;
   logic [1:0] tmeth, nxt_mode;
   logic [2:0] nxt_lim_sel;

   assign tmeth = term_cfg_ff[1:0];
   assign block = spc_cfg_ff[DISCHG_BIT] || !s_uvlo;
   assign charging = (state_ff == ST_TRKL) || (state_ff == ST_CC) ||
                     (state_ff == ST_CV);
   // A recharge restarts both timers at half their programmed time. R16
   assign term_lim = (9'(term_cfg_ff[6:2]) * ((tmeth == TM_CUR_TIMER) ?
                     TERM_SHORT_MIN : TERM_LONG_MIN)) >> half_ff;
   assign safe_lim = SAFETY_MIN >> half_ff;
   assign tmr_evt = phase_run_ff && (phase_min_ff >= term_lim);

   always_comb begin
      nxt_state = state_ff;
      nxt_resume = resume_ff;
      nxt_done = done_ff;
      nxt_fault = fault_ff;
      nxt_timeout = timeout_ff;
      nxt_half = half_ff;
      nxt_phase_run = phase_run_ff;
      nxt_phase_min = phase_min_ff;
      nxt_safe_min = safe_min_ff;
      start = 1'b0;
      nxt_min_cnt = min_cnt_ff + 32'h1;
      if (min_cnt_ff >= MINUTE_CYC - 1) begin
         nxt_min_cnt = 32'h0;
         nxt_phase_min = phase_min_ff + 9'h1;
         nxt_safe_min = charging ? safe_min_ff + 9'h1 : safe_min_ff;
      end
      unique case (state_ff)
         ST_INIT: begin
            if (!block && s_settled) begin
               if (s_below_rch) begin
                  start = 1'b1; // R15
               end else begin
                  nxt_state = ST_STBY; // R15
               end
            end
         end
         ST_STBY: begin
            // The hot threshold sits at about 40 C, so no hot flag is cool.
            if (!block && s_below_rch && !hot_ff &&
                !spc_cfg_ff[DISRCH_BIT]) begin
               start = 1'b1; // R16
               nxt_half = 1'b1; // R16
            end
         end
         ST_HOLD: begin
            if (block) begin
               nxt_state = ST_INIT;
            end else if (!pause) begin
               nxt_state = resume_ff; // R23
            end
         end
         ST_FAULT: begin
            if (spc_cfg_ff[DISCHG_BIT]) begin
               nxt_state = ST_INIT;
               nxt_fault = 1'b0;
            end
         end
         default: begin
            if (block) begin
               nxt_state = ST_INIT;
            end else if (pause) begin
               nxt_resume = state_ff; // R23
               nxt_state = ST_HOLD; // R17
            end else if (safe_min_ff >= safe_lim) begin
               nxt_state = ST_STBY;
               nxt_timeout = 1'b1;
            end else if (state_ff == ST_TRKL) begin
               if (!s_below_trkl) begin
                  nxt_state = ST_CC; // R11
               end else if (phase_min_ff >= TRKL_MIN) begin
                  nxt_state = ST_FAULT; // R10
                  nxt_fault = 1'b1; // R10
               end
            end else if (state_ff == ST_CC) begin
               if (s_float) begin
                  nxt_state = ST_CV; // R13
                  nxt_phase_min = 9'h0;
                  nxt_phase_run = tmeth[0]; // R21
               end
            end else begin
               if (tmeth == TM_CUR_TIMER && s_term_cur && !phase_run_ff) begin
                  nxt_phase_run = 1'b1; // R21
                  nxt_phase_min = 9'h0; // R21
               end
               if (tmr_evt && tmeth != TM_CUR) begin
                  nxt_state = ST_STBY; // R14
                  nxt_timeout = 1'b1;
                  nxt_done = 1'b1;
               end else if (s_term_cur && tmeth[1]) begin
                  nxt_state = ST_STBY; // R14
                  nxt_done = 1'b1;
               end
            end
         end
      endcase
      if (start) begin
         nxt_state = s_below_trkl ? ST_TRKL : ST_CC; // R9
         nxt_phase_min = 9'h0;
         nxt_safe_min = 9'h0;
         nxt_phase_run = 1'b0;
         nxt_done = 1'b0;
         nxt_timeout = 1'b0;
         nxt_half = (state_ff == ST_STBY);
      end
   end

   // Registered outputs, computed from the current state.
   always_comb begin
      if (!s_settled) begin
         nxt_lim_sel = LIM_100MA; // R3
      end else if (lim_cfg_ff[SRC_BIT]) begin
         nxt_lim_sel = lim_cfg_ff[2:0]; // R1
      end else begin
         nxt_lim_sel = s_pin ? LIM_1500MA : LIM_500MA; // R1 R2
      end
      unique case (state_ff)
         ST_TRKL: nxt_mode = MODE_TRKL;
         ST_CC: nxt_mode = MODE_CC;
         ST_CV: nxt_mode = MODE_CV;
         default: nxt_mode = MODE_HOLD;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= ST_INIT;
         resume_ff <= ST_CC;
         min_cnt_ff <= 32'h0;
         phase_min_ff <= 9'h0;
         safe_min_ff <= 9'h0;
         phase_run_ff <= 1'b0;
         half_ff <= 1'b0;
         done_ff <= 1'b0;
         fault_ff <= 1'b0;
         timeout_ff <= 1'b0;
         prereg_en <= 1'b0;
         input_limit_sel <= LIM_100MA;
         charge_en <= 1'b0;
         charge_reduce <= 1'b0;
         charge_mode <= MODE_HOLD;
         trickle_current_code <= 3'h0;
         target_charge_current <= 4'h1;
         float_sel <= 2'h0;
         diode_switch_on <= 1'b0;
         ext_diode_gate_out <= 1'b0;
         discharge_en <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         resume_ff <= nxt_resume;
         min_cnt_ff <= nxt_min_cnt;
         phase_min_ff <= nxt_phase_min;
         safe_min_ff <= nxt_safe_min;
         phase_run_ff <= nxt_phase_run;
         half_ff <= nxt_half;
         done_ff <= nxt_done;
         fault_ff <= nxt_fault;
         timeout_ff <= nxt_timeout;
         prereg_en <= s_uvlo; // R4
         input_limit_sel <= nxt_lim_sel; // R12
         charge_en <= charging && !block && !(s_rail_low &&
                      !spc_cfg_ff[SPRIO_BIT]); // R4 R6 R12
         charge_reduce <= charging && !block && s_rail_low &&
                          spc_cfg_ff[SPRIO_BIT]; // R7
         charge_mode <= nxt_mode;
         trickle_current_code <= app_cfg_ff[7:5]; // R9
         target_charge_current <= (chg_cfg_ff[3:0] == 4'h0) ? 4'h1 :
                                  chg_cfg_ff[3:0]; // R11
         float_sel <= chg_cfg_ff[5:4]; // R13
         diode_switch_on <= s_below_bat; // R8
         ext_diode_gate_out <= s_below_bat; // R8
         discharge_en <= (state_ff == ST_STBY) && done_ff && disch_ff &&
                         !gnd_ff && !s_below_rch; // R19
      end
   end

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   a_limit_startup: assert property (@(posedge clk) disable iff (reset)
      !s_settled |=> input_limit_sel == LIM_100MA) // R3
      else $error("Start-up limit not applied.");
   a_limit_from_reg: assert property (@(posedge clk) disable iff (reset)
      s_settled && lim_cfg_ff[SRC_BIT] |=>
      input_limit_sel == $past(lim_cfg_ff[2:0])) // R1
      else $error("Register limit code not applied.");
   a_limit_from_pin: assert property (@(posedge clk) disable iff (reset)
      s_settled && !lim_cfg_ff[SRC_BIT] |=>
      input_limit_sel == ($past(s_pin) ? LIM_1500MA : LIM_500MA)) // R2
      else $error("Pin limit not applied.");
   a_prereg_lockout: assert property (@(posedge clk) disable iff (reset)
      !s_uvlo |=> !prereg_en && !charge_en) // R4
      else $error("Pre-regulator ran under lockout.");
   a_rail_low_stop: assert property (@(posedge clk) disable iff (reset)
      s_rail_low && !spc_cfg_ff[SPRIO_BIT] |=> !charge_en) // R6
      else $error("Charging kept on low rail.");
   a_reduce_keeps_on: assert property (@(posedge clk) disable iff (reset)
      charge_reduce |-> charge_en) // R7
      else $error("Reduced charge without charging.");
   a_diode_follow: assert property (@(posedge clk) disable iff (reset)
      s_below_bat |=> diode_switch_on && ext_diode_gate_out) // R8
      else $error("Ideal diode not on.");
   a_trickle_fault: assert property (@(posedge clk) disable iff (reset)
      state_ff == ST_TRKL && !block && !pause && s_below_trkl &&
      safe_min_ff < safe_lim && phase_min_ff >= TRKL_MIN |=>
      state_ff == ST_FAULT && fault_ff) // R10
      else $error("Trickle timeout missed.");
   a_bias_window: assert property (@(posedge clk) disable iff (reset)
      thermistor_bias_out |-> meas_cnt_ff < NTC_MEAS_CYC) // R20
      else $error("Thermistor bias held too long.");
   a_ground_no_pause: assert property (@(posedge clk) disable iff (reset)
      state_ff == ST_CC && gnd_ff && !block && !s_float |=>
      state_ff != ST_HOLD) // R18
      else $error("Paused with grounded thermistor.");
   a_done_event: assert property (@(posedge clk) disable iff (reset)
      done_ff && !done_dly_ff |=> evt_ff) // R22
      else $error("Completion event lost.");
endmodule // bccs_charger
`default_nettype wire

// >>> verification/bccs_env.sv
// Behavioural supply rail, battery and thermistor seen by the charger.
`timescale 1ns/100ps
`default_nettype none
module bccs_env (
   input wire logic [12:0] bat,
   input wire logic [12:0] rail,
   input wire logic [8:0] thermistor_sense_pin,
   input wire logic thermistor_bias_out,
   output logic system_rail_low,
   output logic system_rail_below_bat,
   output logic bat_below_trickle,
   output logic bat_at_float,
   output logic bat_below_recharge,
   output logic ntc_hot,
   output logic ntc_cold,
   output logic ntc_grounded,
   output logic ntc_discharge_hot
);
   // Comparators on millivolts; float taken at the 4.10 V setting.
   assign system_rail_low = rail < 13'd3600;
   assign system_rail_below_bat = rail + 13'd15 <= bat;
   assign bat_below_trickle = bat < 13'd2800;
   assign bat_at_float = bat >= 13'd4100;
   assign bat_below_recharge = bat < 13'd3900;
   // Unbiased, the sense node sits at ground and reads hot and shorted.
   assign ntc_hot = !thermistor_bias_out || thermistor_sense_pin <= 9'd54;
   assign ntc_cold = thermistor_bias_out && thermistor_sense_pin >= 9'd325;
   assign ntc_grounded = !thermistor_bias_out || thermistor_sense_pin == 9'd0;
   assign ntc_discharge_hot = !thermistor_bias_out || thermistor_sense_pin <= 9'd25;
endmodule // bccs_env
`default_nettype wire

// >>> verification/tb_battery_charge_control_sequencer.sv
// Self-checking bench for the charge control sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb_battery_charge_control_sequencer import bccs_pkg::*;;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, peek = 0;
   logic limit_select_pin = 0, input_uvlo_ok = 0, rail_settled = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [12:0] bat = 2500, rail = 3800;
   logic [8:0] thermistor_sense_pin = 100;
   logic pready, pslverr, prereg_en, charge_en, charge_reduce;
   logic diode_switch_on, ext_diode_gate_out, thermistor_bias_out;
   logic system_rail_low, system_rail_below_bat, bat_below_trickle;
   logic bat_at_float, bat_below_recharge, ntc_hot, ntc_cold;
   logic ntc_grounded, ntc_discharge_hot, term_current_reached = 0;
   logic [1:0] charge_mode;
   logic [2:0] input_limit_sel, c;
   logic [63:0] q[$], m[$], o, e, mk;
   int miscompares = 0, cmp_count = 0;
   int tv[3] = '{50, 400, 0};
   bccs_charger #(.NTC_PERIOD_CYC(200), .NTC_MEAS_CYC(20), .MINUTE_CYC(50))
      i_bccs_charger (.*, .float_sel(),
      .trickle_current_code(), .target_charge_current(), .discharge_en());
   bccs_env i_bccs_env (.*);
   // Free-running 20 MHz clock.
   always #25 clk = ~clk;
   task automatic note(input logic [63:0] ev, input logic [63:0] mv);
      q.push_back(ev);
      m.push_back(mv);
   endtask
   // One APB transfer, held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [63:0] ev, mv);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      note(ev, mv);
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask
   // Pin answers need several edges, so the caller gives the wait.
   task automatic look(input logic [9:0] ev, mv, input int n);
      repeat (n) @(posedge clk);
      note({54'h0, ev}, {54'h0, mv});
      peek <= 1'b1;
      @(posedge clk);
      peek <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // The oldest note is matched against the answer seen at this edge.
   always @(posedge clk) if (pready === 1'b1 || peek) begin
      o = peek ? {54'h0, charge_reduce, diode_switch_on, ext_diode_gate_out,
         prereg_en, charge_en, charge_mode, input_limit_sel}
         : {31'h0, pslverr, prdata};
      e = q.pop_front();
      mk = m.pop_front();
      cmp_count++;
      if ((o & mk) !== (e & mk)) begin
         miscompares++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e & mk, o & mk);
      end
   end
   // Watchdog well beyond the few thousand cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      tally_and_finish;
   end
   // Main sequence.
   initial begin
      void'($urandom(32'h4414));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      apb(0, LIM_ADDR, 0, LIM_RST, 64'h1_ffff_ffff);
      apb(0, 8'h1c, 0, 64'h1_0000_0000, 64'h1_ffff_ffff);
      input_uvlo_ok <= 1'b1;
      look({5'h02, MODE_HOLD, LIM_100MA}, 10'h07f, 8);
      rail_settled <= 1'b1;
      look({5'h03, MODE_TRKL, LIM_100MA}, 10'h07f, 10);
      apb(1, LIM_ADDR, 0, 0, 64'h1_0000_0000);
      for (int i = 0; i < 2; i++) begin
         limit_select_pin <= i[0];
         look({7'h0, i ? LIM_1500MA : LIM_500MA}, 10'h007, 6);
      end
      repeat (3) begin
         c = 3'($urandom % 5);
         apb(1, LIM_ADDR, {24'h0, 5'h10, c}, 0, 64'h1_0000_0000);
         look({7'h0, c}, 10'h007, 3);
      end
      repeat (1600) @(posedge clk);
      apb(0, STAT_ADDR, 0, 64'h21, 64'h21);
      bat <= 13'd3000;
      apb(1, SPC_ADDR, 32'h1, 0, 64'h1_0000_0000);
      apb(1, SPC_ADDR, 32'h0, 0, 64'h1_0000_0000);
      look({5'h01, MODE_CC, 3'h0}, 10'h038, 12);
      rail <= 13'd3500;
      look({5'h00, MODE_HOLD, 3'h0}, 10'h020, 6);
      apb(1, SPC_ADDR, 32'h20, 0, 64'h1_0000_0000);
      look({5'h11, MODE_CC, 3'h0}, 10'h238, 8);
      rail <= 13'd2900;
      look({5'h0c, 5'h0}, 10'h180, 6);
      rail <= 13'd3800;
      foreach (tv[i]) begin
         thermistor_sense_pin <= 9'(tv[i]);
         look({5'h0, i == 2 ? MODE_CC : MODE_HOLD, 3'h0}, 10'h018, 450);
         thermistor_sense_pin <= 9'd100;
         look({5'h0, MODE_CC, 3'h0}, 10'h018, 450);
      end
      bat <= 13'd4150;
      look({5'h0, MODE_CV, 3'h0}, 10'h018, 8);
      term_current_reached <= 1'b1;
      look({5'h0, MODE_HOLD, 3'h0}, 10'h038, 200);
      apb(0, EVT_ADDR, 0, 1, 64'h1_ffff_ffff);
      apb(1, EVT_ADDR, 1, 0, 64'h1_0000_0000);
      apb(0, EVT_ADDR, 0, 0, 64'h1);
      apb(0, STAT_ADDR, 0, 64'h840, 64'hc58);
      thermistor_sense_pin <= 9'd20;
      repeat (450) @(posedge clk);
      apb(0, STAT_ADDR, 0, 64'h100, 64'h100);
      {bat, thermistor_sense_pin} <= {13'd3800, 9'd100};
      look({5'h0, MODE_CC, 3'h0}, 10'h018, 450);
      tally_and_finish;
   end
endmodule // tb_battery_charge_control_sequencer
`default_nettype wire
